/* File: sawc_pkg.sv */
// Purpose: constants for sleep and watchdog control
// Assumes: 40 MHz system clock, axi4-lite register access
// Notes:   register offsets are byte addresses
`default_nettype none
package sawc_pkg;
   localparam logic [3:0] OFS_WDOG_CTRL  = 4'h0;
   localparam logic [3:0] OFS_CPU_STATUS = 4'h4;
   localparam logic [3:0] OFS_IRQ_CTRL   = 4'h8;
   localparam logic [3:0] OFS_SLEEP_STAT = 4'hc;
   // watchdog control fields
   localparam int        WDC_SWEN_BIT   = 0;
   localparam int        WDC_PS_LSB     = 1;
   localparam logic [4:0] WDC_PS_RESET  = 5'h0b;
   localparam logic [4:0] WDC_PS_MAXCODE = 5'h12;
   // cpu status fields
   localparam int        ST_PD_BIT      = 3;
   localparam int        ST_TO_BIT      = 4;
   // irq control fields
   localparam int        IC_GIE_BIT     = 7;
   // watchdog modes
   localparam logic [1:0] WDM_ALWAYS_OFF = 2'h0;
   localparam logic [1:0] WDM_SOFTWARE   = 2'h1;
   localparam logic [1:0] WDM_OFF_SLEEP  = 2'h2;
   localparam logic [1:0] WDM_ALWAYS_ON  = 2'h3;
   // counts
   localparam int        PRESCALE_MIN_LOG2 = 5;
   localparam int        WDT_CNT_W      = 24;
   localparam int        OST_CYCLES     = 1024;
   localparam logic [10:0] OST_LAST     = 11'(OST_CYCLES - 1);
   localparam logic [15:0] IRQ_VECTOR   = 16'h0004;
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;
   typedef enum logic [3:0] {
      ST_RUN   = 4'b0001,
      ST_ENTER = 4'b0010,
      ST_SLEEP = 4'b0100,
      ST_OST   = 4'b1000
   } sawc_state_e;
endpackage
`default_nettype wire

/* File: sawc_sleep_wdog.sv */
// Purpose: sleep sequencing and watchdog timer
// Assumes: lfoTick marks one low-frequency oscillator period, synchronous
// Notes:   axi4-lite slave, one write and one read at a time
// Behaviour
// - sleep entered only by sleep instruction
// - sleep entry clears powerdown, sets timeout flag
// - cpu clock gated, low-frequency oscillator kept
// - io ports hold their drive during sleep
// - resets reset device; watchdog, interrupts resume
// - enabled interrupt wakes regardless of global enable
// - after irq wake, vector only if global enable
// - prefetch next instruction during sleep instruction
// - any wake clears watchdog counter
// - pending enabled irq makes sleep a no-op
// - irq during sleep entry completes then wakes
// - crystal modes delay wake by 1024 cycles
// - watchdog timeout without clear resets device
// - watchdog counts only low-frequency oscillator ticks
// - mode 11 keeps watchdog always active
// - mode 10 active awake, off asleep
// - mode 01 follows software enable bit
// - period select from 1 ms, default 2 s
// - watchdog cleared on listed events
// - timeout asleep wakes instead of reset
// - code 0 is 1:32, doubling; reserved minimum
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module sawc_sleep_wdog (
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   input  wire logic [1:0]  watchdogModeConfig,
   input  wire logic        crystalMode,
   input  wire logic        lfoTick,
   input  wire logic        sleepInstr,
   input  wire logic        watchdogClearInstr,
   input  wire logic        irqPendingEnabled,
   input  wire logic        oscFailEvent,
   input  wire logic        oscTick,
   input  wire logic        pinDriveLevel,
   input  wire logic        pinDriveEnable,
   output logic             cpuClockEnable,
   output logic             lfoRunEnable,
   output logic             prefetchNext,
   output logic             resumeStrobe,
   output logic             vectorStrobe,
   output logic [15:0]      vectorAddr,
   output logic             watchdogResetReq,
   output logic             asleep,
   output logic             pinOut,
   output logic             pinOutEnable,
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   import sawc_pkg::*;

   typedef struct packed {
      sawc_state_e                    state;
      logic [4:0]                     periodSel;
      logic                           swEnable;
      logic                           global_irq_enable;
      logic                           pdFlag;
      logic                           toFlag;
      logic [WDT_CNT_W-1:0]           wdtCnt;
      logic [10:0]                    ostCnt;
      logic                           resumePend;
      logic                           resume;
      logic                           vector;
      logic                           wdReset;
      logic                           prefetch;
      logic                           pinHold;
      logic                           pinHoldEn;
      logic                           awHeld;
      logic                           wHeld;
      logic [3:0]                     awAddr;
      logic [31:0]                    wData;
      logic [3:0]                     wStrb;
      logic                           bValid;
      logic [1:0]                     bResp;
      logic                           rValid;
      logic [31:0]                    rData;
      logic [1:0]                     rResp;
   } sawc_regs_s;

   sawc_regs_s q, d;

   function automatic logic mapped(input logic [3:0] a);
      mapped = (a == OFS_WDOG_CTRL) || (a == OFS_CPU_STATUS) ||
               (a == OFS_IRQ_CTRL) || (a == OFS_SLEEP_STAT);
   endfunction

   // prescale terminal count: 2^(5+code)-1, reserved codes minimum
   function automatic logic [WDT_CNT_W-1:0] period_last(
      input logic [4:0] code);
      logic [4:0] c;
      c = (code > WDC_PS_MAXCODE) ? 5'h00 : code;
      period_last = WDT_CNT_W'((32'h1 << (PRESCALE_MIN_LOG2 + c)) - 1);
   endfunction

   logic wdActive;
   logic wdClear;
   logic wrFire;
   logic asleepNow;

   always_comb begin
      asleepNow = (q.state == ST_SLEEP) || (q.state == ST_OST);
      case (watchdogModeConfig)
         WDM_ALWAYS_ON: wdActive = 1'b1;
         WDM_OFF_SLEEP: wdActive = !asleepNow;
         WDM_SOFTWARE:  wdActive = q.swEnable;
         default:       wdActive = 1'b0;
      endcase
      wrFire = q.awHeld && q.wHeld && !q.bValid;
   end

   always_comb begin
      d = q;
      d.resume = 1'b0;
      d.vector = 1'b0;
      d.wdReset = 1'b0;
      d.prefetch = 1'b0;
      wdClear = !wdActive || oscFailEvent;
      if (q.state == ST_RUN && watchdogClearInstr) begin
         wdClear = 1'b1;
      end
      // pins follow core while awake, freeze during sleep entry and while asleep
      if (!asleepNow && q.state != ST_ENTER) begin
         d.pinHold = pinDriveLevel;
         d.pinHoldEn = pinDriveEnable;
      end
      if (q.resume && q.global_irq_enable) begin
         d.vector = 1'b1;
      end
      case (q.state)
         ST_RUN: begin
            if (sleepInstr) begin
               d.prefetch = 1'b1;
               if (!irqPendingEnabled) begin
                  d.state = ST_ENTER;
                  d.pdFlag = 1'b0;
                  d.toFlag = 1'b1;
                  wdClear = 1'b1;
               end
            end
         end
         ST_ENTER: begin
            d.state = ST_SLEEP;
            wdClear = 1'b1;
            // irq arriving during entry still completes entry
            d.resumePend = irqPendingEnabled;
         end
         ST_SLEEP: begin
            if (q.resumePend || irqPendingEnabled) begin
               d.resumePend = 1'b0;
               wdClear = 1'b1;
               d.ostCnt = '0;
               d.state = crystalMode ? ST_OST : ST_RUN;
               d.resume = !crystalMode;
            end
         end
         ST_OST: begin
            wdClear = 1'b1;
            if (oscTick) begin
               d.ostCnt = q.ostCnt + 11'h001;
               if (q.ostCnt == OST_LAST) begin
                  d.state = ST_RUN;
                  d.resume = 1'b1;
               end
            end
         end
         default: d.state = ST_RUN;
      endcase
      // watchdog counter on low-frequency ticks only
      if (wdClear) begin
         d.wdtCnt = '0;
      end else if (lfoTick) begin
         if (q.wdtCnt >= period_last(q.periodSel)) begin
            d.wdtCnt = '0;
            if (q.state == ST_SLEEP) begin
               d.state = crystalMode ? ST_OST : ST_RUN;
               d.ostCnt = '0;
               d.resume = !crystalMode;
               d.toFlag = 1'b0;
               d.pdFlag = 1'b0;
            end else begin
               d.wdReset = 1'b1;
            end
         end else begin
            d.wdtCnt = q.wdtCnt + WDT_CNT_W'(1);
         end
      end
      // axi write path
      if (s_axi_awvalid && !q.awHeld) begin
         d.awHeld = 1'b1;
         d.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !q.wHeld) begin
         d.wHeld = 1'b1;
         d.wData = s_axi_wdata;
         d.wStrb = s_axi_wstrb;
      end
      if (wrFire) begin
         d.awHeld = 1'b0;
         d.wHeld = 1'b0;
         d.bValid = 1'b1;
         d.bResp = mapped(q.awAddr) ? RESP_OKAY : RESP_SLVERR;
         if (q.wStrb[0]) begin
            case (q.awAddr)
               OFS_WDOG_CTRL: begin
                  d.swEnable = q.wData[WDC_SWEN_BIT];
                  d.periodSel = q.wData[WDC_PS_LSB +: 5];
               end
               OFS_IRQ_CTRL: d.global_irq_enable = q.wData[IC_GIE_BIT];
               default: d.global_irq_enable = d.global_irq_enable;
            endcase
         end
      end
      if (q.bValid && s_axi_bready) begin
         d.bValid = 1'b0;
      end
      // axi read path
      if (s_axi_arvalid && !q.rValid) begin
         d.rValid = 1'b1;
         d.rResp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         case (s_axi_araddr)
            OFS_WDOG_CTRL:
               d.rData = {26'h0, q.periodSel, q.swEnable};
            OFS_CPU_STATUS:
               d.rData = {27'h0, q.toFlag, q.pdFlag, 3'h0};
            OFS_IRQ_CTRL:
               d.rData = {24'h0, q.global_irq_enable, 7'h0};
            OFS_SLEEP_STAT:
               d.rData = {4'h0, q.wdtCnt, q.state};
            default: d.rData = 32'h0;
         endcase
      end else if (q.rValid && s_axi_rready) begin
         d.rValid = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
         q.state <= ST_RUN;
         q.periodSel <= WDC_PS_RESET;
         q.pdFlag <= 1'b1;
         q.toFlag <= 1'b1;
      end else begin
         q <= d;
      end
   end

   always_comb begin
      asleep = asleepNow;
      cpuClockEnable = !asleepNow && q.state != ST_ENTER;
      lfoRunEnable = 1'b1;
      prefetchNext = q.prefetch;
      resumeStrobe = q.resume;
      vectorStrobe = q.vector;
      vectorAddr = IRQ_VECTOR;
      watchdogResetReq = q.wdReset;
      pinOut = q.pinHold;
      pinOutEnable = q.pinHoldEn;
      s_axi_awready = !q.awHeld;
      s_axi_wready = !q.wHeld;
      s_axi_bvalid = q.bValid;
      s_axi_bresp = q.bResp;
      s_axi_arready = !q.rValid;
      s_axi_rvalid = q.rValid;
      s_axi_rdata = q.rData;
      s_axi_rresp = q.rResp;
   end
endmodule
`default_nettype wire

/* File: sawc_sleep_wdog_properties.sv */
// Purpose: port assertions for sleep and watchdog control
// Assumes: one clock domain, async active-low reset
// Notes:   bound to the design module by the bind statement below
`timescale 1ns/100ps
`default_nettype none
module sawc_sleep_wdog_chk (
   input wire logic       clk_sys,
   input wire logic       resetn,
   input wire logic [1:0] watchdogModeConfig,
   input wire logic       crystalMode,
   input wire logic       sleepInstr,
   input wire logic       irqPendingEnabled,
   input wire logic       cpuClockEnable,
   input wire logic       lfoRunEnable,
   input wire logic       prefetchNext,
   input wire logic       resumeStrobe,
   input wire logic       vectorStrobe,
   input wire logic       watchdogResetReq,
   input wire logic       asleep,
   input wire logic       pinOut,
   input wire logic       pinOutEnable
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);
   a_sleep_cause: assert property ($fell(cpuClockEnable) |-> $past(sleepInstr))
      else $error("cpu clock gated without sleep");
   a_gate_cpu: assert property (asleep |-> !cpuClockEnable)
      else $error("cpu clock running asleep");
   a_lfo_kept: assert property (lfoRunEnable)
      else $error("slow oscillator stopped");
   a_pins_hold: assert property (asleep |-> $stable(pinOut) && $stable(pinOutEnable))
      else $error("pin changed asleep");
   a_irq_wake: assert property (asleep && irqPendingEnabled && !crystalMode
      |-> ##[1:3] resumeStrobe)
      else $error("no wake on irq");
   a_vector_after: assert property (vectorStrobe |-> $past(resumeStrobe))
      else $error("vector without resume");
   a_prefetch_cause: assert property (prefetchNext |-> $past(sleepInstr))
      else $error("prefetch without sleep");
   a_off_quiet: assert property (watchdogModeConfig == 2'h0 |-> !watchdogResetReq)
      else $error("reset in off mode");
endmodule
bind sawc_sleep_wdog sawc_sleep_wdog_chk i_sawc_sleep_wdog_chk (.clk_sys, .resetn,
   .watchdogModeConfig, .crystalMode, .sleepInstr, .irqPendingEnabled,
   .cpuClockEnable, .lfoRunEnable, .prefetchNext, .resumeStrobe, .vectorStrobe,
   .watchdogResetReq, .asleep, .pinOut, .pinOutEnable);
`default_nettype wire

/* File: sleep_and_watchdog_control_tb_top.sv */
// Purpose: directed bench for sleep and watchdog control
// Assumes: lfoTick and oscTick held high act as one tick per cycle
// Notes:   registers reached over axi4-lite
`timescale 1ns/100ps
`default_nettype none
module sleep_and_watchdog_control_tb_top;
   import sawc_pkg::*;
   logic clk_sys = 0, resetn = 0, crystalMode = 0, lfoTick = 0, oscTick = 0;
   logic sleepInstr = 0, watchdogClearInstr = 0, irqPendingEnabled = 0;
   logic oscFailEvent = 0, pinDriveLevel = 1, pinDriveEnable = 1;
   logic [1:0] watchdogModeConfig = 2'h0, s_axi_bresp, s_axi_rresp;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, cpuClockEnable, lfoRunEnable, prefetchNext;
   logic resumeStrobe, vectorStrobe, watchdogResetReq, asleep, pinOut, pinOutEnable;
   logic [15:0] vectorAddr;
   int n_fail = 0, cmp_count = 0, cyc = 0, n;
   sawc_sleep_wdog i_sawc_sleep_wdog (.clk_sys, .resetn, .watchdogModeConfig,
      .crystalMode, .lfoTick, .sleepInstr, .watchdogClearInstr, .irqPendingEnabled,
      .oscFailEvent, .oscTick, .pinDriveLevel, .pinDriveEnable, .cpuClockEnable,
      .lfoRunEnable, .prefetchNext, .resumeStrobe, .vectorStrobe, .vectorAddr,
      .watchdogResetReq, .asleep, .pinOut, .pinOutEnable, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   always #12.5 clk_sys = ~clk_sys;
   task automatic test_done;
      $display("fails %0d compares %0d", n_fail, cmp_count);
      if (n_fail == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         test_done;
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic axw(input logic [3:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask
   task automatic axr(input logic [3:0] a, input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      chk(32'(s_axi_rresp), 32'(er));
      s_axi_rready <= 1'b0;
   endtask
   task automatic waitSig(input bit w, input int lim);
      n = 0;
      while ((w ? watchdogResetReq : resumeStrobe) !== 1'b1 && n < lim) begin
         @(posedge clk_sys);
         n++;
      end
   endtask
   task automatic doSleep;
      sleepInstr <= 1'b1;
      @(posedge clk_sys);
      sleepInstr <= 1'b0;
      @(posedge clk_sys);
      chk(prefetchNext, 1'b1);
      repeat (3) @(posedge clk_sys);
   endtask
   task automatic tSleep(input logic g, input logic x);
      axw(OFS_IRQ_CTRL, {24'h0, g, 7'h0});
      crystalMode <= x;
      oscTick <= x;
      doSleep;
      chk(asleep, 1'b1);
      chk(cpuClockEnable, 1'b0);
      axr(OFS_CPU_STATUS, RESP_OKAY);
      chk(rd, 32'h10);
      pinDriveLevel <= ~pinDriveLevel;
      @(posedge clk_sys);
      chk(pinOut, !pinDriveLevel);
      irqPendingEnabled <= 1'b1;
      waitSig(0, 1200);
      irqPendingEnabled <= 1'b0;
      chk(x ? n >= 1024 && n < 1100 : n < 4, 1'b1);
      @(posedge clk_sys);
      chk(vectorStrobe, g);
      chk(vectorAddr, IRQ_VECTOR);
      crystalMode <= 1'b0;
      oscTick <= 1'b0;
   endtask
   task automatic tWd(input logic [1:0] m, input logic [31:0] c, input bit e);
      axw(OFS_WDOG_CTRL, c);
      watchdogModeConfig <= m;
      watchdogClearInstr <= 1'b1;
      repeat (3) @(posedge clk_sys);
      watchdogClearInstr <= 1'b0;
      waitSig(1, 80);
      chk(e ? n >= 28 && n <= 36 : n == 80, 1'b1);
   endtask
   initial begin
      repeat (16) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      axr(OFS_WDOG_CTRL, RESP_OKAY);
      chk(rd, 32'h16);
      axw(OFS_CPU_STATUS, 32'h0);
      axr(OFS_CPU_STATUS, RESP_OKAY);
      chk(rd, 32'h18);
      axr(4'h2, RESP_SLVERR);
      tSleep(0, 0);
      tSleep(1, 0);
      tSleep(1, 1);
      resetn <= 1'b0;
      @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      irqPendingEnabled <= 1'b1;
      doSleep;
      irqPendingEnabled <= 1'b0;
      chk(asleep, 1'b0);
      axr(OFS_CPU_STATUS, RESP_OKAY);
      chk(rd, 32'h18);
      lfoTick <= 1'b1;
      tWd(WDM_ALWAYS_ON, 32'h0, 1);
      tWd(WDM_SOFTWARE, 32'h1, 1);
      tWd(WDM_SOFTWARE, 32'h0, 0);
      tWd(WDM_ALWAYS_OFF, 32'h1, 0);
      tWd(WDM_OFF_SLEEP, 32'h26, 1);
      doSleep;
      waitSig(0, 80);
      chk(n, 80);
      irqPendingEnabled <= 1'b1;
      waitSig(0, 10);
      irqPendingEnabled <= 1'b0;
      watchdogModeConfig <= WDM_ALWAYS_ON;
      doSleep;
      waitSig(0, 80);
      chk(n < 40, 1'b1);
      axr(OFS_CPU_STATUS, RESP_OKAY);
      chk(rd, 32'h0);
      test_done;
   end
endmodule
`default_nettype wire
